/* pkg/fcsc_pkg.sv */
// ----------------------------------------------------------------
// Shared constants and types for the fast call selector check unit
// ----------------------------------------------------------------
package fcsc_pkg;
  // Selector geometry
  localparam int FCSC_SEL_W = 16;
  localparam int FCSC_NULL_LSB = 2; // Index and table bits start here
  localparam int FCSC_NSEG = 6;
  localparam int FCSC_SEG_W = 3;
  localparam int FCSC_MSR_W = 32;
  localparam int FCSC_DATA_W = 32;

  // Segment register numbering
  localparam logic [2:0] FCSC_SEG_ES = 3'h0;
  localparam logic [2:0] FCSC_SEG_CS = 3'h1;
  localparam logic [2:0] FCSC_SEG_SS = 3'h2;
  localparam logic [2:0] FCSC_SEG_DS = 3'h3;
  localparam logic [2:0] FCSC_SEG_FS = 3'h4;
  localparam logic [2:0] FCSC_SEG_GS = 3'h5;

  // Derivation lanes, each one adder plus a null test
  localparam int FCSC_NDRV = 5;
  localparam int FCSC_DRV_LOAD = 0;
  localparam int FCSC_DRV_ENTRY_CS = 1;
  localparam int FCSC_DRV_ENTRY_SS = 2;
  localparam int FCSC_DRV_EXIT_CS = 3;
  localparam int FCSC_DRV_EXIT_SS = 4;
  localparam logic [15:0] FCSC_OFS_NONE = 16'h0000;
  localparam logic [15:0] FCSC_OFS_ENTRY_SS = 16'h0008;
  localparam logic [15:0] FCSC_OFS_EXIT_CS = 16'h0010;
  localparam logic [15:0] FCSC_OFS_EXIT_SS = 16'h0018;
  localparam logic [15:0] FCSC_DRV_OFS [FCSC_NDRV] = '{FCSC_OFS_NONE, FCSC_OFS_NONE,
    FCSC_OFS_ENTRY_SS, FCSC_OFS_EXIT_CS, FCSC_OFS_EXIT_SS};

  // Values after reset
  localparam logic [15:0] FCSC_SEL_RST = 16'h0000;
  localparam logic FCSC_NULL_RST = 1'b1;
  localparam logic [15:0] FCSC_BASE_RST = 16'h0000;
  localparam logic [31:0] FCSC_RDATA_RST = 32'h0000_0000;
  localparam logic [15:0] FCSC_GP_CODE = 16'h0000;

  // Requests
  typedef enum logic [2:0] {
    FCSC_OP_SEG_LOAD = 3'h0,
    FCSC_OP_MEM_USE = 3'h1,
    FCSC_OP_ENTRY = 3'h2,
    FCSC_OP_EXIT = 3'h3,
    FCSC_OP_MSR_RD = 3'h4,
    FCSC_OP_MSR_WR = 3'h5
  } fcsc_op_t;

  // Exception classes
  typedef enum logic [1:0] {
    FCSC_EXC_NONE = 2'h0,
    FCSC_EXC_GP = 2'h1,
    FCSC_EXC_STACK = 2'h2
  } fcsc_exc_t;

  // Sequencer, Gray along idle, exec, resp
  typedef enum logic [1:0] {
    FCSC_ST_IDLE = 2'h0,
    FCSC_ST_EXEC = 2'h1,
    FCSC_ST_RESP = 2'h3
  } fcsc_state_t;
endpackage

/* core/fcsc_sel_derive.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Selector adder with null detection
// ----------------------------------------------------------------
module fcsc_sel_derive (
  input wire logic [15:0] base_sel,
  input wire logic [15:0] offset,
  output logic [15:0] sum_sel,
  output logic sum_null
);
  import fcsc_pkg::*;

  // Sixteen-bit add, carry out dropped so the sum wraps
  always_comb begin
    sum_sel = 16'(base_sel + offset);
  end

  // Privilege bits play no part in the null test
  always_comb begin
    sum_null = ~|sum_sel[FCSC_SEL_W-1:FCSC_NULL_LSB];
  end
endmodule

/* core/fcsc_msr_check.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Model register index decode
// ----------------------------------------------------------------
module fcsc_msr_check #(
  parameter logic [31:0] IMPL_LO = 32'h0000_0000,
  parameter logic [31:0] IMPL_HI = 32'h0000_00ff,
  parameter logic [31:0] BASE_INDEX = 32'h0000_0100
) (
  input wire logic [fcsc_pkg::FCSC_MSR_W-1:0] index,
  output logic idx_valid,
  output logic idx_is_base
);
  import fcsc_pkg::*;

  // Base register sits outside the plain window
  always_comb begin
    idx_is_base = (index == BASE_INDEX);
    idx_valid = idx_is_base || ((index >= IMPL_LO) && (index <= IMPL_HI));
  end
endmodule

/* core/fcsc_top.sv */
`timescale 1ns/1ps
module fcsc_top #(
  parameter logic [31:0] IMPL_LO = 32'h0000_0000,
  parameter logic [31:0] IMPL_HI = 32'h0000_00ff,
  parameter logic [31:0] BASE_INDEX = 32'h0000_0100
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic op_valid,
  input wire fcsc_pkg::fcsc_op_t op_kind,
  input wire logic [fcsc_pkg::FCSC_SEG_W-1:0] op_seg,
  input wire logic [fcsc_pkg::FCSC_SEL_W-1:0] op_selector,
  input wire logic [fcsc_pkg::FCSC_MSR_W-1:0] op_msr_index,
  input wire logic [fcsc_pkg::FCSC_DATA_W-1:0] op_wdata,
  output logic op_ready,
  output logic done,
  output logic exc_valid,
  output fcsc_pkg::fcsc_exc_t exc_vector,
  output logic [15:0] exc_code,
  output logic [fcsc_pkg::FCSC_DATA_W-1:0] rdata,
  output logic [fcsc_pkg::FCSC_SEL_W-1:0] fast_call_code_selector_base,
  output logic [fcsc_pkg::FCSC_SEL_W-1:0] cs_selector,
  output logic [fcsc_pkg::FCSC_SEL_W-1:0] ss_selector,
  output logic [fcsc_pkg::FCSC_NSEG*fcsc_pkg::FCSC_SEL_W-1:0] seg_sel_flat,
  output logic [fcsc_pkg::FCSC_NSEG-1:0] seg_null
);
  import fcsc_pkg::*;

  // ----------------------------------------------------------------
  // Request capture and sequencer
  // ----------------------------------------------------------------
  fcsc_state_t state_r; // Sequencer state
  fcsc_state_t state_nxt; // Its next value
  fcsc_op_t req_op_r; // Captured request kind
  logic [FCSC_SEG_W-1:0] req_seg_r; // Captured segment number
  logic [15:0] req_sel_r; // Captured explicit selector
  logic [FCSC_MSR_W-1:0] req_idx_r; // Captured register index
  logic [FCSC_DATA_W-1:0] req_wdata_r; // Captured write data
  logic take; // Request accepted this cycle

  assign take = op_valid && op_ready;

  // Next state; one request in flight keeps the segment file coherent
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      FCSC_ST_IDLE: begin
        if (take) begin
          state_nxt = FCSC_ST_EXEC;
        end
      end
      FCSC_ST_EXEC: begin
        state_nxt = FCSC_ST_RESP;
      end
      FCSC_ST_RESP: begin
        state_nxt = FCSC_ST_IDLE;
      end
      default: begin
        state_nxt = FCSC_ST_IDLE; // Illegal code recovers to idle
      end
    endcase
  end

  // State register
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      state_r <= FCSC_ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Ready flop, registered so the output has no path from inputs
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      op_ready <= 1'b1;
    end else begin
      op_ready <= (state_nxt == FCSC_ST_IDLE) && !take;
    end
  end

  // Request latch
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      req_op_r <= FCSC_OP_SEG_LOAD;
      req_seg_r <= FCSC_SEG_ES;
      req_sel_r <= FCSC_SEL_RST;
      req_idx_r <= FCSC_RDATA_RST;
      req_wdata_r <= FCSC_RDATA_RST;
    end else if (take) begin
      req_op_r <= op_kind;
      req_seg_r <= op_seg;
      req_sel_r <= op_selector;
      req_idx_r <= op_msr_index;
      req_wdata_r <= op_wdata;
    end
  end

  // ----------------------------------------------------------------
  // Selector derivation lanes
  // ----------------------------------------------------------------
  logic [15:0] drv_sel [FCSC_NDRV]; // Derived selectors
  logic drv_null [FCSC_NDRV]; // Their null tests

  // Lane zero checks the explicit selector, the rest start from the base
  generate
    for (genvar gi = 0; gi < FCSC_NDRV; gi++) begin : g_drv
      fcsc_sel_derive u_drv (
        .base_sel((gi == FCSC_DRV_LOAD) ? req_sel_r : fast_call_code_selector_base),
        .offset(FCSC_DRV_OFS[gi]),
        .sum_sel(drv_sel[gi]),
        .sum_null(drv_null[gi])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // Model register index check
  // ----------------------------------------------------------------
  logic idx_valid; // Index is implemented
  logic idx_is_base; // Index names the base register

  fcsc_msr_check #(
    .IMPL_LO(IMPL_LO),
    .IMPL_HI(IMPL_HI),
    .BASE_INDEX(BASE_INDEX)
  ) u_msr (
    .index(req_idx_r),
    .idx_valid(idx_valid),
    .idx_is_base(idx_is_base)
  );

  // ----------------------------------------------------------------
  // Execution decode
  // ----------------------------------------------------------------
  logic [FCSC_NSEG-1:0] wr_en; // Segment update strobes
  logic [15:0] wr_sel [FCSC_NSEG]; // Segment update values
  logic [FCSC_NSEG-1:0] wr_null; // Segment update null flags
  fcsc_exc_t exc_nxt; // Exception raised by this request
  logic base_wr; // Base register write
  logic [FCSC_DATA_W-1:0] rdata_nxt; // Read return
  logic exec; // Request in execution

  assign exec = (state_r == FCSC_ST_EXEC);

  // One decode per request; faults block every architectural update
  always_comb begin
    wr_en = '0;
    wr_null = '0;
    for (int i = 0; i < FCSC_NSEG; i++) begin
      wr_sel[i] = req_sel_r;
    end
    exc_nxt = FCSC_EXC_NONE;
    base_wr = 1'b0;
    rdata_nxt = FCSC_RDATA_RST;
    if (exec) begin
      unique case (req_op_r)
        FCSC_OP_SEG_LOAD: begin
          if (drv_null[FCSC_DRV_LOAD] && ((req_seg_r == FCSC_SEG_CS) || (req_seg_r == FCSC_SEG_SS))) begin
            exc_nxt = FCSC_EXC_GP;
          end else begin
            wr_en[req_seg_r] = 1'b1;
            wr_null[req_seg_r] = drv_null[FCSC_DRV_LOAD];
          end
        end
        FCSC_OP_MEM_USE: begin
          // Stack segment reports as a stack exception, others as protection
          if (seg_null[req_seg_r]) begin
            exc_nxt = (req_seg_r == FCSC_SEG_SS) ? FCSC_EXC_STACK : FCSC_EXC_GP;
          end
        end
        FCSC_OP_ENTRY: begin
          // Null result is kept and flagged, never faulted here
          wr_en[FCSC_SEG_CS] = 1'b1;
          wr_sel[FCSC_SEG_CS] = drv_sel[FCSC_DRV_ENTRY_CS];
          wr_null[FCSC_SEG_CS] = drv_null[FCSC_DRV_ENTRY_CS];
          wr_en[FCSC_SEG_SS] = 1'b1;
          wr_sel[FCSC_SEG_SS] = drv_sel[FCSC_DRV_ENTRY_SS];
          wr_null[FCSC_SEG_SS] = drv_null[FCSC_DRV_ENTRY_SS];
        end
        FCSC_OP_EXIT: begin
          wr_en[FCSC_SEG_CS] = 1'b1;
          wr_sel[FCSC_SEG_CS] = drv_sel[FCSC_DRV_EXIT_CS];
          wr_null[FCSC_SEG_CS] = drv_null[FCSC_DRV_EXIT_CS];
          wr_en[FCSC_SEG_SS] = 1'b1;
          wr_sel[FCSC_SEG_SS] = drv_sel[FCSC_DRV_EXIT_SS];
          wr_null[FCSC_SEG_SS] = drv_null[FCSC_DRV_EXIT_SS];
        end
        FCSC_OP_MSR_RD: begin
          if (!idx_valid) begin
            exc_nxt = FCSC_EXC_GP;
          end else if (idx_is_base) begin
            rdata_nxt = {{(FCSC_DATA_W-FCSC_SEL_W){1'b0}}, fast_call_code_selector_base};
          end
        end
        FCSC_OP_MSR_WR: begin
          if (!idx_valid) begin
            exc_nxt = FCSC_EXC_GP;
          end else begin
            base_wr = idx_is_base;
          end
        end
        default: begin
          exc_nxt = FCSC_EXC_NONE; // Unused op codes do nothing
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Segment file, one lane per register
  // ----------------------------------------------------------------
  generate
    for (genvar gs = 0; gs < FCSC_NSEG; gs++) begin : g_seg
      // Selector and null flag always move together
      always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
          seg_sel_flat[gs*FCSC_SEL_W +: FCSC_SEL_W] <= FCSC_SEL_RST;
          seg_null[gs] <= FCSC_NULL_RST;
        end else if (wr_en[gs]) begin
          seg_sel_flat[gs*FCSC_SEL_W +: FCSC_SEL_W] <= wr_sel[gs];
          seg_null[gs] <= wr_null[gs];
        end
      end
    end
  endgenerate

  // Copies of CS and SS for direct observation
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      cs_selector <= FCSC_SEL_RST;
      ss_selector <= FCSC_SEL_RST;
    end else begin
      if (wr_en[FCSC_SEG_CS]) begin
        cs_selector <= wr_sel[FCSC_SEG_CS];
      end
      if (wr_en[FCSC_SEG_SS]) begin
        ss_selector <= wr_sel[FCSC_SEG_SS];
      end
    end
  end

  // Base register; only the low sixteen bits are kept
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      fast_call_code_selector_base <= FCSC_BASE_RST;
    end else if (base_wr) begin
      fast_call_code_selector_base <= req_wdata_r[FCSC_SEL_W-1:0];
    end
  end

  // ----------------------------------------------------------------
  // Response
  // ----------------------------------------------------------------
  // Fault and read fields hold until the next request executes; done pulses for one cycle
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      done <= 1'b0;
      exc_valid <= 1'b0;
      exc_vector <= FCSC_EXC_NONE;
      exc_code <= FCSC_GP_CODE;
      rdata <= FCSC_RDATA_RST;
    end else begin
      done <= exec;
      if (exec) begin
        exc_valid <= (exc_nxt != FCSC_EXC_NONE);
        exc_vector <= exc_nxt;
        exc_code <= FCSC_GP_CODE;
        rdata <= rdata_nxt;
      end
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  sequence s_take(fcsc_op_t k);
    op_valid && op_ready && (op_kind == k);
  endsequence

  sequence s_ok;
    done && !exc_valid;
  endsequence

  sequence s_gp0;
    done && exc_valid && (exc_vector == FCSC_EXC_GP) && (exc_code == 16'h0000);
  endsequence

  a_cs_ss_null: assert property (s_take(FCSC_OP_SEG_LOAD) ##0 ((op_seg == FCSC_SEG_CS) ||
    (op_seg == FCSC_SEG_SS)) && (op_selector[15:2] == 14'h0000) |-> ##2 s_gp0)
    else $error("null cs/ss load did not fault");
  a_other_null_ok: assert property (s_take(FCSC_OP_SEG_LOAD) ##0 (op_seg != FCSC_SEG_CS) &&
    (op_seg != FCSC_SEG_SS) && (op_seg < 3'h6) |-> ##2 s_ok ##0 seg_null[$past(op_seg, 2)] ==
    ($past(op_selector, 2) < 16'h0004))
    else $error("other segment load mishandled");
  a_mem_null_exc: assert property (s_take(FCSC_OP_MEM_USE) ##0 (op_seg < 3'h6) ##0 seg_null[op_seg]
    |-> ##2 done && exc_valid)
    else $error("memory use through null segment not faulted");
  a_entry_ss_sum: assert property (s_take(FCSC_OP_ENTRY) |-> ##2
    ss_selector == 16'($past(fast_call_code_selector_base, 2) + 16'h0008))
    else $error("entry ss selector wrong");
  a_entry_null: assert property (s_take(FCSC_OP_ENTRY) ##0 (fast_call_code_selector_base >= 16'hfff8) &&
    (fast_call_code_selector_base <= 16'hfffb) |-> ##2 seg_null[FCSC_SEG_SS])
    else $error("entry null ss not flagged");
  a_entry_no_fault: assert property (s_take(FCSC_OP_ENTRY) |-> !done ##1 !done ##1 s_ok)
    else $error("entry raised a fault");
  a_exit_derive: assert property (s_take(FCSC_OP_EXIT) |-> ##2 s_ok ##0
    (cs_selector == 16'($past(fast_call_code_selector_base, 2) + 16'h0010)) &&
    (ss_selector == 16'($past(fast_call_code_selector_base, 2) + 16'h0018)))
    else $error("exit selectors wrong");
  a_exit_null: assert property (s_take(FCSC_OP_EXIT) |-> ##2
    (seg_null[FCSC_SEG_SS] == (($past(fast_call_code_selector_base, 2) >> 2) == 16'h3ffa)) &&
    (seg_null[FCSC_SEG_CS] == (($past(fast_call_code_selector_base, 2) >> 2) == 16'h3ffc)))
    else $error("exit null flags wrong");
  a_msr_reject: assert property ((s_take(FCSC_OP_MSR_RD) or s_take(FCSC_OP_MSR_WR)) ##0
    ((op_msr_index < IMPL_LO) || (op_msr_index > IMPL_HI)) && (op_msr_index != BASE_INDEX) |-> ##2 s_gp0)
    else $error("bad index not rejected");
  a_null_flag_def: assert property ((seg_null[FCSC_SEG_CS] == (cs_selector[15:2] == 14'h0000)) &&
    (seg_null[FCSC_SEG_SS] == (ss_selector[15:2] == 14'h0000)))
    else $error("null flag disagrees with selector");
  a_busy_spacing: assert property (op_valid && op_ready |-> ##1 !op_ready [*2] ##1 op_ready)
    else $error("request spacing wrong");
endmodule

/* verification/tb_top.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Self-checking bench for the fast call selector check unit
// ----------------------------------------------------------------
module tb_top;
  import fcsc_pkg::*;
  // Model register index map handed to the design
  localparam logic [31:0] IMPL_LO = 32'h0000_0000;
  localparam logic [31:0] IMPL_HI = 32'h0000_00ff;
  localparam logic [31:0] BASE_INDEX = 32'h0000_0100;
  logic sys_clk;
  logic rstn;
  logic op_valid;
  fcsc_op_t op_kind;
  logic [FCSC_SEG_W-1:0] op_seg;
  logic [FCSC_SEL_W-1:0] op_selector;
  logic [FCSC_MSR_W-1:0] op_msr_index;
  logic [FCSC_DATA_W-1:0] op_wdata;
  logic op_ready;
  logic done;
  logic exc_valid;
  fcsc_exc_t exc_vector;
  logic [15:0] exc_code;
  logic [FCSC_DATA_W-1:0] rdata;
  logic [FCSC_SEL_W-1:0] base_sel;
  logic [FCSC_SEL_W-1:0] cs_selector;
  logic [FCSC_SEL_W-1:0] ss_selector;
  logic [FCSC_NSEG*FCSC_SEL_W-1:0] seg_sel_flat;
  logic [FCSC_NSEG-1:0] seg_null;
  int failures = 0; // Mismatch count
  int compares = 0; // Comparison count

  fcsc_top #(.IMPL_LO(IMPL_LO), .IMPL_HI(IMPL_HI), .BASE_INDEX(BASE_INDEX)) fcsc_top_inst (
    .sys_clk(sys_clk), .rstn(rstn), .op_valid(op_valid), .op_kind(op_kind), .op_seg(op_seg),
    .op_selector(op_selector), .op_msr_index(op_msr_index), .op_wdata(op_wdata),
    .op_ready(op_ready), .done(done), .exc_valid(exc_valid), .exc_vector(exc_vector),
    .exc_code(exc_code), .rdata(rdata), .fast_call_code_selector_base(base_sel),
    .cs_selector(cs_selector), .ss_selector(ss_selector), .seg_sel_flat(seg_sel_flat),
    .seg_null(seg_null));

  // ----------------------------------------------------------------
  // Clock and shared helpers
  // ----------------------------------------------------------------
  initial sys_clk = 1'b0;
  // 100 MHz clock
  always #5 sys_clk = ~sys_clk;

  // Null test worked out here, not borrowed from the design
  function automatic logic nul(input logic [15:0] s);
    return s[15:2] == 14'h0000;
  endfunction

  // One comparison; case inequality so unknowns never match
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Verdict and end of run, shared with the watchdog
  task automatic results();
    $display("Counts: compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // One request: held until taken, then waits for done under a bound
  task automatic run_op(input fcsc_op_t k, input logic [2:0] s, input logic [15:0] sel,
                        input logic [31:0] idx, input logic [31:0] wd);
    int n;
    @(negedge sys_clk);
    op_kind = k;
    op_seg = s;
    op_selector = sel;
    op_msr_index = idx;
    op_wdata = wd;
    op_valid = 1'b1;
    n = 0;
    while (op_ready !== 1'b1 && n < 10) begin
      @(negedge sys_clk);
      n++;
    end
    // Taken at this edge; release only after it
    @(posedge sys_clk);
    @(negedge sys_clk);
    op_valid = 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 10) begin
      @(negedge sys_clk);
      n++;
    end
    check("done", 32'(done), 32'h1);
  endtask

  // Exception outcome of the last request
  task automatic chk_exc(input fcsc_exc_t v);
    check("exc_valid", 32'(exc_valid), 32'(v != FCSC_EXC_NONE));
    check("exc_vector", 32'(exc_vector), 32'(v));
    check("exc_code", 32'(exc_code), 32'h0);
  endtask

  // Base register written through the model register path
  task automatic set_base(input logic [15:0] b);
    run_op(FCSC_OP_MSR_WR, 3'h0, 16'h0000, BASE_INDEX, {16'h5a5a, b});
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  // Reset, then the values that must follow it
  task automatic t_reset();
    rstn = 1'b0;
    repeat (5) @(negedge sys_clk);
    rstn = 1'b1;
    check("ready", 32'(op_ready), 32'h1);
    check("seg_null", 32'(seg_null), 32'h3f);
    check("cs", 32'(cs_selector), 32'h0);
    check("ss", 32'(ss_selector), 32'h0);
    check("base", 32'(base_sel), 32'h0);
    check("exc_valid", 32'(exc_valid), 32'h0);
    check("done", 32'(done), 32'h0);
    check("rdata", rdata, 32'h0);
  endtask

  // Model register index checking, base index, upper valid edge and bad indices
  task automatic t_msr();
    logic [31:0] bad [3];
    bad = '{32'h0000_0101, 32'h8000_0000, 32'hffff_ffff};
    set_base(16'hfff8);
    chk_exc(FCSC_EXC_NONE);
    check("base", 32'(base_sel), 32'h0000_fff8);
    run_op(FCSC_OP_MSR_RD, 3'h0, 16'h0000, BASE_INDEX, 32'h0);
    check("rdata", rdata, 32'h0000_fff8);
    run_op(FCSC_OP_MSR_RD, 3'h0, 16'h0000, IMPL_HI, 32'h0);
    chk_exc(FCSC_EXC_NONE);
    check("rdata", rdata, 32'h0);
    foreach (bad[i]) begin
      run_op(FCSC_OP_MSR_RD, 3'h0, 16'h0000, bad[i], 32'h0);
      chk_exc(FCSC_EXC_GP);
      run_op(FCSC_OP_MSR_WR, 3'h0, 16'h0000, bad[i], 32'h0000_1234);
      chk_exc(FCSC_EXC_GP);
      check("base kept", 32'(base_sel), 32'h0000_fff8);
    end
  endtask

  // Explicit loads: non-null everywhere, then null with RPL bits set
  task automatic t_load();
    logic cs_ss;
    for (int s = 0; s < FCSC_NSEG; s++) begin
      run_op(FCSC_OP_SEG_LOAD, 3'(s), 16'h0004, 32'h0, 32'h0);
      chk_exc(FCSC_EXC_NONE);
      check("flag", 32'(seg_null[s]), 32'h0);
    end
    for (int s = 0; s < FCSC_NSEG; s++) begin
      cs_ss = (3'(s) == FCSC_SEG_CS) || (3'(s) == FCSC_SEG_SS);
      run_op(FCSC_OP_SEG_LOAD, 3'(s), 16'h0003, 32'h0, 32'h0);
      chk_exc(cs_ss ? FCSC_EXC_GP : FCSC_EXC_NONE);
      check("sel", 32'(seg_sel_flat[16*s +: 16]), cs_ss ? 32'h4 : 32'h3);
      check("flag", 32'(seg_null[s]), 32'(!cs_ss));
    end
    // Memory use through each segment
    for (int s = 0; s < FCSC_NSEG; s++) begin
      cs_ss = (3'(s) == FCSC_SEG_CS) || (3'(s) == FCSC_SEG_SS);
      run_op(FCSC_OP_MEM_USE, 3'(s), 16'h0000, 32'h0, 32'h0);
      chk_exc(cs_ss ? FCSC_EXC_NONE : FCSC_EXC_GP);
    end
  endtask

  // Entry across the null window and the wrap point
  task automatic t_entry();
    logic [15:0] b [5];
    logic [15:0] e;
    b = '{16'h0010, 16'hfff7, 16'hfff8, 16'hfffb, 16'hfffc};
    foreach (b[i]) begin
      e = b[i] + 16'h0008;
      set_base(b[i]);
      run_op(FCSC_OP_ENTRY, 3'h0, 16'h0000, 32'h0, 32'h0);
      chk_exc(FCSC_EXC_NONE);
      check("cs", 32'(cs_selector), 32'(b[i]));
      check("ss", 32'(ss_selector), 32'(e));
      check("ss flag", 32'(seg_null[FCSC_SEG_SS]), 32'(nul(e)));
      // Deferred fault shows on the first stack use
      run_op(FCSC_OP_MEM_USE, FCSC_SEG_SS, 16'h0000, 32'h0, 32'h0);
      chk_exc(nul(e) ? FCSC_EXC_STACK : FCSC_EXC_NONE);
    end
  endtask

  // Exit across both null windows, both edges of the stack window and the upper edge of the code window
  task automatic t_exit();
    logic [15:0] b [8];
    logic [15:0] c;
    logic [15:0] e;
    b = '{16'h0020, 16'hffe7, 16'hffe8, 16'hffeb, 16'hffec, 16'hfff0, 16'hfff3, 16'hfff4};
    foreach (b[i]) begin
      c = b[i] + 16'h0010;
      e = b[i] + 16'h0018;
      set_base(b[i]);
      run_op(FCSC_OP_EXIT, 3'h0, 16'h0000, 32'h0, 32'h0);
      chk_exc(FCSC_EXC_NONE);
      check("cs", 32'(cs_selector), 32'(c));
      check("ss", 32'(ss_selector), 32'(e));
      check("cs flag", 32'(seg_null[FCSC_SEG_CS]), 32'(nul(c)));
      check("ss flag", 32'(seg_null[FCSC_SEG_SS]), 32'(nul(e)));
      check("ss lane", 32'(seg_sel_flat[16*FCSC_SEG_SS +: 16]), 32'(e));
      run_op(FCSC_OP_MEM_USE, FCSC_SEG_SS, 16'h0000, 32'h0, 32'h0);
      chk_exc(nul(e) ? FCSC_EXC_STACK : FCSC_EXC_NONE);
      // Null code segment faults on its first use, as a protection fault
      run_op(FCSC_OP_MEM_USE, FCSC_SEG_CS, 16'h0000, 32'h0, 32'h0);
      chk_exc(nul(c) ? FCSC_EXC_GP : FCSC_EXC_NONE);
    end
  endtask

  // ----------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    rstn = 1'b0;
    op_valid = 1'b0;
    op_kind = FCSC_OP_SEG_LOAD;
    op_seg = 3'h0;
    op_selector = 16'h0000;
    op_msr_index = 32'h0;
    op_wdata = 32'h0;
    t_reset();
    t_msr();
    t_load();
    t_entry();
    t_exit();
    // Second reset after traffic must clear everything again
    t_reset();
    results();
  end

  // Roughly 74 requests of a few cycles each; far more margin than needed
  initial begin
    #200000;
    failures++;
    results();
  end
endmodule
